// [core/trace_prog_ctrl.sv]
`timescale 1ns/1ps
// How it works
// - Enable set moves Idle to Enabling
// - Enabling reaches Running within bounded time
// - Enable cleared moves Running to Unstable
// - Unstable reaches Stable within bounded time
// - Stable to Idle once drained and quiet
// - Status idle and stable bits follow state
// - Dynamic fields frozen in Stable and Idle
// - Outside Idle, most register writes ignored
// - Enable change ignored outside Idle or Running
// - Table registers visible to direct reads quickly
// - Earlier instructions keep previous enable state
// - New enable governs after context sync
// - Indirect writes reach direct reads at sync in Stable or Idle
// - Indirect writes published entering Stable or Idle
// - Internal reads and writes in order
// - Debugger writes visible to internal reads
// - Debugger writes visible to debugger reads
// - Stable or Idle: internal writes reach debugger
// - Authentication change is an internal write
module trace_prog_ctrl (
   // Clock and asynchronous reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Direct port: system instructions of the traced processor
   input  wire logic        dir_wr,
   input  wire logic        dir_rd,
   input  wire logic [3:0]  dir_sel,
   input  wire logic [31:0] dir_wdata,
   output logic      [31:0] dir_rdata,
   input  wire logic        ctx_sync,
   // External debug port
   input  wire logic        ext_wr,
   input  wire logic        ext_rd,
   input  wire logic [3:0]  ext_sel,
   input  wire logic [31:0] ext_wdata,
   output logic      [31:0] ext_rdata,
   // Internal trace functions
   input  wire logic        ind_wr,
   input  wire logic        ind_rd,
   input  wire logic [3:0]  ind_sel,
   input  wire logic [31:0] ind_wdata,
   output logic      [31:0] ind_rdata,
   // Quiescence and authentication
   input  wire logic        trace_drained,
   input  wire logic        ext_quiet_pin,
   input  wire logic [7:0]  auth_pin,
   // Status
   output logic             status_idle,
   output logic             model_stable_flag,
   output logic             trace_enable,
   output logic      [2:0]  prog_state
);

   localparam int          NREG   = trace_prog_pkg::NREG;
   localparam int          EN_BOUND     = trace_prog_pkg::ENABLE_CYCLES + 2;
   localparam int          SETTLE_BOUND = trace_prog_pkg::SETTLE_CYCLES + 2;
   localparam int          EN_BIT = trace_prog_pkg::EN_BIT;

   typedef struct packed {
      trace_prog_pkg::prog_state_t  state;
      logic                         en_eff;
      logic [NREG-1:0][31:0]        live;
      logic [NREG-1:0][31:0]        pub;
      logic [NREG-1:0][31:0]        dview;
      logic [31:0]                  dir_rdata;
      logic [31:0]                  ext_rdata;
      logic [31:0]                  ind_rdata;
   } ctrl_t;

   ctrl_t       r;
   ctrl_t       n;
   logic        rst_n;
   logic        ext_quiet;
   logic [7:0]  auth_s;
   logic        en_done;
   logic        settle_done;
   logic        frozen;
   logic        ext_ok;
   logic        dir_ok;
   logic [31:0] stat_w;

   // Reset asserts at once, releases after two edges
   sync2 #(.W(1)) u_rst_sync (
      .core_clk (core_clk),
      .rst_n    (reset_n),
      .d        (1'b1),
      .q        (rst_n)
   );

   // Pins from outside the clock domain
   sync2 #(.W(9)) u_pin_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        ({ext_quiet_pin, auth_pin}),
      .q        ({ext_quiet, auth_s})
   );

   // Bounded settling after enable and after disable
   phase_timer #(
      .W     (trace_prog_pkg::TMR_W),
      .LIMIT (trace_prog_pkg::TMR_W'(trace_prog_pkg::ENABLE_CYCLES))
   ) u_en_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (r.state == trace_prog_pkg::ST_ENABLING),
      .done     (en_done)
   );

   phase_timer #(
      .W     (trace_prog_pkg::TMR_W),
      .LIMIT (trace_prog_pkg::TMR_W'(trace_prog_pkg::SETTLE_CYCLES))
   ) u_settle_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (r.state == trace_prog_pkg::ST_UNSTABLE),
      .done     (settle_done)
   );

   // Fields that only move while tracing
   function automatic logic dynamic_reg(input logic [3:0] sel);
      dynamic_reg = (sel == trace_prog_pkg::SEL_CNTVAL) || (sel == trace_prog_pkg::SEL_SEQST)
                 || (sel == trace_prog_pkg::SEL_SSCSTAT) || (sel == trace_prog_pkg::SEL_RSR)
                 || (sel == trace_prog_pkg::SEL_VICTL);
   endfunction

   // Registers whose updates direct reads see without a sync
   function automatic logic table_reg(input logic [3:0] sel);
      table_reg = (sel == trace_prog_pkg::SEL_CLAIMSET) || (sel == trace_prog_pkg::SEL_CLAIMCLR)
               || (sel == trace_prog_pkg::SEL_CNTVAL) || (sel == trace_prog_pkg::SEL_SEQST)
               || (sel == trace_prog_pkg::SEL_SSCSTAT);
   endfunction

   // New register value; claim set and clear act bitwise
   function automatic logic [31:0] apply(input logic [31:0] old, input logic [3:0] sel,
                                         input logic [31:0] w);
      logic [31:0] m;
      m = w & trace_prog_pkg::reg_mask(sel);
      if (sel == trace_prog_pkg::SEL_CLAIMSET)
         apply = old | m;
      else if (sel == trace_prog_pkg::SEL_CLAIMCLR)
         apply = old & ~m;
      else
         apply = m;
   endfunction

   // Gate for direct and external writes
   function automatic logic write_ok(input trace_prog_pkg::prog_state_t st, input logic [3:0] sel,
                                     input logic [31:0] w, input logic en_now);
      if (sel == trace_prog_pkg::SEL_PRGCTL)
         write_ok = (w[EN_BIT] == en_now) || (st == trace_prog_pkg::ST_IDLE)
                 || (st == trace_prog_pkg::ST_RUNNING);
      else if ((sel == trace_prog_pkg::SEL_CLAIMSET) || (sel == trace_prog_pkg::SEL_CLAIMCLR))
         write_ok = 1'b1;
      else if (sel == trace_prog_pkg::SEL_STATUS)
         write_ok = 1'b0;
      else
         write_ok = (st == trace_prog_pkg::ST_IDLE);
   endfunction

   // Status word built from the state
   function automatic logic [31:0] status_word(input trace_prog_pkg::prog_state_t st);
      logic [31:0] s;
      s = '0;
      s[trace_prog_pkg::IDLE_BIT]   = (st == trace_prog_pkg::ST_IDLE) || (st == trace_prog_pkg::ST_ENABLING);
      s[trace_prog_pkg::STABLE_BIT] = (st == trace_prog_pkg::ST_IDLE) || (st == trace_prog_pkg::ST_STABLE);
      status_word = s;
   endfunction

   assign frozen = (r.state == trace_prog_pkg::ST_IDLE) || (r.state == trace_prog_pkg::ST_STABLE);
   assign ext_ok = write_ok(r.state, ext_sel, ext_wdata, r.live[trace_prog_pkg::SEL_PRGCTL][EN_BIT]);
   assign dir_ok = write_ok(r.state, dir_sel, dir_wdata, r.live[trace_prog_pkg::SEL_PRGCTL][EN_BIT]);

   // Writes land internal first, then debugger, then direct; all in one cycle looks atomic
   always_comb
   begin
      n = r;
      if (ind_wr && (ind_sel != trace_prog_pkg::SEL_STATUS) && !(frozen && dynamic_reg(ind_sel)))
         n.live[trace_prog_pkg::slot(ind_sel)] =
            apply(r.live[trace_prog_pkg::slot(ind_sel)], ind_sel, ind_wdata);
      // Authentication pins behave as an internal writer
      if (auth_s != r.live[trace_prog_pkg::SEL_AUTH][7:0])
         n.live[trace_prog_pkg::SEL_AUTH] = {24'h000000, auth_s};
      if (ext_wr && ext_ok)
      begin
         n.live[trace_prog_pkg::slot(ext_sel)] =
            apply(n.live[trace_prog_pkg::slot(ext_sel)], ext_sel, ext_wdata);
         // Debugger enable writes have no program order to respect
         if (ext_sel == trace_prog_pkg::SEL_PRGCTL)
            n.en_eff = ext_wdata[EN_BIT];
      end
      if (dir_wr && dir_ok)
         n.live[trace_prog_pkg::slot(dir_sel)] =
            apply(n.live[trace_prog_pkg::slot(dir_sel)], dir_sel, dir_wdata);
      // Direct enable writes only take hold at a context sync
      if (ctx_sync)
         n.en_eff = n.live[trace_prog_pkg::SEL_PRGCTL][EN_BIT];

      // Programming state machine
      case (r.state)
         trace_prog_pkg::ST_IDLE:
            if (r.en_eff)
               n.state = trace_prog_pkg::ST_ENABLING;
         trace_prog_pkg::ST_ENABLING:
            if (en_done)
               n.state = trace_prog_pkg::ST_RUNNING;
         trace_prog_pkg::ST_RUNNING:
            if (!r.en_eff)
               n.state = trace_prog_pkg::ST_UNSTABLE;
         trace_prog_pkg::ST_UNSTABLE:
            if (settle_done)
               n.state = trace_prog_pkg::ST_STABLE;
         trace_prog_pkg::ST_STABLE:
            if (trace_drained && ext_quiet)
               n.state = trace_prog_pkg::ST_IDLE;
         default:
            n.state = trace_prog_pkg::ST_IDLE;
      endcase

      // Debugger view: live while quiescent, else held from last entry except for debugger writes
      if ((n.state == trace_prog_pkg::ST_IDLE) || (n.state == trace_prog_pkg::ST_STABLE))
         n.pub = n.live;
      else if (ext_wr && ext_ok)
         n.pub[trace_prog_pkg::slot(ext_sel)] = n.live[trace_prog_pkg::slot(ext_sel)];

      // Direct view: refreshed by a sync while quiescent, own writes at once
      if (ctx_sync && frozen)
         n.dview = n.live;
      else if (dir_wr && dir_ok)
         n.dview[trace_prog_pkg::slot(dir_sel)] = n.live[trace_prog_pkg::slot(dir_sel)];

      // Read data, one cycle after the strobe
      if (dir_rd)
      begin
         if (dir_sel == trace_prog_pkg::SEL_STATUS)
            n.dir_rdata = status_word(r.state);
         else if (table_reg(dir_sel))
            n.dir_rdata = r.live[trace_prog_pkg::slot(dir_sel)];
         else
            n.dir_rdata = r.dview[trace_prog_pkg::slot(dir_sel)];
      end
      if (ext_rd)
      begin
         if (ext_sel == trace_prog_pkg::SEL_STATUS)
            n.ext_rdata = status_word(r.state);
         else if (table_reg(ext_sel))
            n.ext_rdata = r.live[trace_prog_pkg::slot(ext_sel)];
         else
            n.ext_rdata = r.pub[trace_prog_pkg::slot(ext_sel)];
      end
      if (ind_rd)
      begin
         if (ind_sel == trace_prog_pkg::SEL_STATUS)
            n.ind_rdata = status_word(r.state);
         else
            n.ind_rdata = r.live[trace_prog_pkg::slot(ind_sel)];
      end
   end

   // All state clears to Idle with enable low
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r       <= '0;
         r.state <= trace_prog_pkg::ST_IDLE;
      end
      else
         r <= n;
   end

   // Outputs
   assign dir_rdata         = r.dir_rdata;
   assign ext_rdata         = r.ext_rdata;
   assign ind_rdata         = r.ind_rdata;
   assign stat_w            = status_word(r.state);
   assign status_idle       = stat_w[trace_prog_pkg::IDLE_BIT];
   assign model_stable_flag = stat_w[trace_prog_pkg::STABLE_BIT];
   assign trace_enable      = (r.state == trace_prog_pkg::ST_ENABLING) || (r.state == trace_prog_pkg::ST_RUNNING);
   assign prog_state        = r.state;

   // Checks
   property p_idle_enable;
      @(posedge core_clk) disable iff (!rst_n)
      (r.state == trace_prog_pkg::ST_IDLE) && r.en_eff |=> (r.state == trace_prog_pkg::ST_ENABLING);
   endproperty
   a_idle_enable: assert property (p_idle_enable) else $error("idle did not start enabling");

   property p_enable_bound;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(r.state == trace_prog_pkg::ST_ENABLING) |-> ##[1:EN_BOUND] (r.state == trace_prog_pkg::ST_RUNNING);
   endproperty
   a_enable_bound: assert property (p_enable_bound) else $error("enabling did not reach running");

   property p_run_disable;
      @(posedge core_clk) disable iff (!rst_n)
      (r.state == trace_prog_pkg::ST_RUNNING) && !r.en_eff |=> (r.state == trace_prog_pkg::ST_UNSTABLE);
   endproperty
   a_run_disable: assert property (p_run_disable) else $error("running did not become unstable");

   property p_settle_bound;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(r.state == trace_prog_pkg::ST_UNSTABLE) |-> ##[1:SETTLE_BOUND] (r.state == trace_prog_pkg::ST_STABLE);
   endproperty
   a_settle_bound: assert property (p_settle_bound) else $error("unstable did not reach stable");

   property p_stable_exit;
      @(posedge core_clk) disable iff (!rst_n)
      (r.state == trace_prog_pkg::ST_STABLE) ##1 (r.state == trace_prog_pkg::ST_IDLE)
         |-> $past(trace_drained) && $past(ext_quiet);
   endproperty
   a_stable_exit: assert property (p_stable_exit) else $error("idle entered before quiescence");

   property p_unstable_status;
      @(posedge core_clk) disable iff (!rst_n)
      (r.state == trace_prog_pkg::ST_UNSTABLE) |-> !model_stable_flag && !status_idle;
   endproperty
   a_unstable_status: assert property (p_unstable_status) else $error("status wrong while unstable");

   property p_frozen_count;
      @(posedge core_clk) disable iff (!rst_n)
      frozen && !ext_wr && !dir_wr |=> $stable(r.live[trace_prog_pkg::SEL_CNTVAL]);
   endproperty
   a_frozen_count: assert property (p_frozen_count) else $error("counter moved while frozen");

   property p_busy_write;
      @(posedge core_clk) disable iff (!rst_n)
      (r.state != trace_prog_pkg::ST_IDLE) && !ind_wr && (dir_wr || ext_wr)
         |=> $stable(r.live[trace_prog_pkg::SEL_VICTL]);
   endproperty
   a_busy_write: assert property (p_busy_write) else $error("write took effect outside idle");

   property p_en_locked;
      @(posedge core_clk) disable iff (!rst_n)
      (r.state == trace_prog_pkg::ST_UNSTABLE) |=> $stable(r.live[trace_prog_pkg::SEL_PRGCTL][EN_BIT]);
   endproperty
   a_en_locked: assert property (p_en_locked) else $error("enable changed while unstable");

   property p_direct_defer;
      @(posedge core_clk) disable iff (!rst_n)
      dir_wr && !ctx_sync && !ext_wr |=> $stable(r.en_eff);
   endproperty
   a_direct_defer: assert property (p_direct_defer) else $error("direct write bypassed sync");

   property p_sync_apply;
      @(posedge core_clk) disable iff (!rst_n)
      ctx_sync && !dir_wr && !ext_wr |=> (r.en_eff == $past(r.live[trace_prog_pkg::SEL_PRGCTL][EN_BIT]));
   endproperty
   a_sync_apply: assert property (p_sync_apply) else $error("sync did not apply enable");

   property p_publish;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(r.state == trace_prog_pkg::ST_STABLE) |-> (r.pub == r.live);
   endproperty
   a_publish: assert property (p_publish) else $error("stable entry did not publish");

endmodule // trace_prog_ctrl

// [core/trace_prog_pkg.sv]
package trace_prog_pkg;

   // Register access geometry
   localparam int          DATA_W = 32;
   localparam int          SEL_W  = 4;
   localparam int          NREG   = 10;
   localparam int          AUTH_W = 8;

   // Register selects shared by all three access ports
   localparam logic [3:0]  SEL_PRGCTL   = 4'h0;
   localparam logic [3:0]  SEL_STATUS   = 4'h1;
   localparam logic [3:0]  SEL_CLAIMSET = 4'h2;
   localparam logic [3:0]  SEL_CLAIMCLR = 4'h3;
   localparam logic [3:0]  SEL_CNTVAL   = 4'h4;
   localparam logic [3:0]  SEL_SEQST    = 4'h5;
   localparam logic [3:0]  SEL_SSCSTAT  = 4'h6;
   localparam logic [3:0]  SEL_RSR      = 4'h7;
   localparam logic [3:0]  SEL_VICTL    = 4'h8;
   localparam logic [3:0]  SEL_AUTH     = 4'h9;

   // Field positions
   localparam int          EN_BIT     = 0;
   localparam int          IDLE_BIT   = 0;
   localparam int          STABLE_BIT = 1;

   // Writable bits of each register
   localparam logic [31:0] MASK_PRGCTL = 32'h0000_0001;
   localparam logic [31:0] MASK_CLAIM  = 32'h0000_00FF;
   localparam logic [31:0] MASK_CNTVAL = 32'h0000_FFFF;
   localparam logic [31:0] MASK_SEQST  = 32'h0000_0003;
   localparam logic [31:0] MASK_SSC    = 32'h0000_0001;
   localparam logic [31:0] MASK_RSR    = 32'h000F_100F;
   localparam logic [31:0] MASK_VICTL  = 32'h0000_0200;
   localparam logic [31:0] MASK_AUTH   = 32'h0000_00FF;
   localparam logic [31:0] REG_RESET   = 32'h0000_0000;

   // Settling bounds, longest times rounded down to whole cycles
   localparam int          CLK_PERIOD_NS   = 50;
   localparam int          ENABLE_TIME_NS  = 200;
   localparam int          SETTLE_TIME_NS  = 400;
   localparam int          ENABLE_CYCLES   = (ENABLE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : ENABLE_TIME_NS / CLK_PERIOD_NS;
   localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : SETTLE_TIME_NS / CLK_PERIOD_NS;
   localparam int          TMR_W           = 8;

   typedef enum logic [2:0] {ST_IDLE, ST_ENABLING, ST_RUNNING, ST_UNSTABLE, ST_STABLE} prog_state_t;

   // Writable bits for a select; read-only status has none
   function automatic logic [31:0] reg_mask(input logic [3:0] sel);
      case (sel)
         SEL_PRGCTL:                 reg_mask = MASK_PRGCTL;
         SEL_CLAIMSET, SEL_CLAIMCLR: reg_mask = MASK_CLAIM;
         SEL_CNTVAL:                 reg_mask = MASK_CNTVAL;
         SEL_SEQST:                  reg_mask = MASK_SEQST;
         SEL_SSCSTAT:                reg_mask = MASK_SSC;
         SEL_RSR:                    reg_mask = MASK_RSR;
         SEL_VICTL:                  reg_mask = MASK_VICTL;
         SEL_AUTH:                   reg_mask = MASK_AUTH;
         default:                    reg_mask = REG_RESET;
      endcase
   endfunction

   // Claim clear works on the claim set storage
   function automatic logic [3:0] slot(input logic [3:0] sel);
      slot = (sel == SEL_CLAIMCLR) ? SEL_CLAIMSET : sel;
   endfunction

endpackage

// [core/sync2.sv]
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Asynchronous level in, synchronised level out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } sync_t;

   sync_t r, n;

   // First stage feeds only the second stage
   always_comb
   begin
      n      = r;
      n.meta = d;
      n.held = r.meta;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         r <= '0;
      else
         r <= n;
   end

   assign q = r.held;

endmodule // sync2

// [core/phase_timer.sv]
`timescale 1ns/1ps
module phase_timer #(
   parameter int           W     = 8,
   parameter logic [W-1:0] LIMIT = 8'h04
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Count while run is high; done once LIMIT cycles have passed
   input  wire logic run,
   output logic      done
);

   typedef struct packed {
      logic [W-1:0] count;
   } tmr_t;

   tmr_t r, n;

   // Saturating count, cleared whenever run drops
   always_comb
   begin
      n = r;
      if (!run)
         n.count = '0;
      else if (r.count != LIMIT)
         n.count = r.count + W'(1);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         r <= '0;
      else
         r <= n;
   end

   assign done = run && (r.count == LIMIT);

endmodule // phase_timer

// [tb/quiesce_model.sv]
`timescale 1ns/1ps
// Far side: trace drains and pins go quiet a while after tracing stops
module quiesce_model #(
   parameter int DRAIN = 20
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Unit state seen from outside
   input  wire logic [2:0] prog_state,
   // Quiescence and authentication levels
   output logic            trace_drained,
   output logic            ext_quiet_pin,
   output logic [7:0]      auth_pin
);
   logic [7:0] cnt_r;
   // Busy while tracing, so the drain wait is never skipped
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
         cnt_r <= 8'h00;
      else if (prog_state == 3'h1 || prog_state == 3'h2)
         cnt_r <= 8'h00;
      else if (cnt_r < 8'(DRAIN))
         cnt_r <= cnt_r + 8'h01;
   assign trace_drained = (cnt_r == 8'(DRAIN));
   assign ext_quiet_pin = trace_drained;
   assign auth_pin      = 8'h3C; // Arbitrary level
endmodule // quiesce_model

// [tb/trace_prog_ctrl_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module trace_prog_ctrl_tb;
   logic        core_clk, reset_n, ctx_sync, trace_drained, ext_quiet_pin;
   logic        wr_s [3];
   logic        rd_s [3];
   logic [3:0]  sel_s [3];
   logic [31:0] wd_s [3];
   logic [31:0] rdv [3];
   logic [7:0]  auth_pin;
   logic        status_idle, model_stable_flag, trace_enable;
   logic [2:0]  prog_state;
   int          n_errors, compares;

   trace_prog_ctrl trace_prog_ctrl_inst (.core_clk(core_clk), .reset_n(reset_n),
      .dir_wr(wr_s[0]), .dir_rd(rd_s[0]), .dir_sel(sel_s[0]), .dir_wdata(wd_s[0]), .dir_rdata(rdv[0]),
      .ctx_sync(ctx_sync),
      .ext_wr(wr_s[1]), .ext_rd(rd_s[1]), .ext_sel(sel_s[1]), .ext_wdata(wd_s[1]), .ext_rdata(rdv[1]),
      .ind_wr(wr_s[2]), .ind_rd(rd_s[2]), .ind_sel(sel_s[2]), .ind_wdata(wd_s[2]), .ind_rdata(rdv[2]),
      .trace_drained(trace_drained), .ext_quiet_pin(ext_quiet_pin), .auth_pin(auth_pin),
      .status_idle(status_idle), .model_stable_flag(model_stable_flag), .trace_enable(trace_enable),
      .prog_state(prog_state));
   quiesce_model quiesce_model_inst (.core_clk(core_clk), .reset_n(reset_n), .prog_state(prog_state),
      .trace_drained(trace_drained), .ext_quiet_pin(ext_quiet_pin), .auth_pin(auth_pin));

   // 20 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic final_report();
      $display("compares %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One access on port p (0 direct, 1 external, 2 internal); reads land a cycle later
   task automatic acc(input int p, input logic w, input logic [3:0] s, input logic [31:0] d);
      @(posedge core_clk);
      #1;
      wr_s[p] = w;
      rd_s[p] = !w;
      sel_s[p] = s;
      wd_s[p] = d;
      @(posedge core_clk);
      #1;
      wr_s[p] = 1'b0;
      rd_s[p] = 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   // Context sync pulse of one cycle
   task automatic sync_pulse();
      ctx_sync = 1'b1;
      @(posedge core_clk) #1 ctx_sync = 1'b0;
   endtask

   task automatic rdchk(input int p, input logic [3:0] s, input logic [31:0] e);
      acc(p, 1'b0, s, 32'h0000_0000);
      `CHK("read data", e, rdv[p])
   endtask

   // Bounded wait; running out ends the run
   task automatic wait_st(input logic [2:0] e, input int lim);
      for (int i = 0; i < lim && prog_state !== e; i++)
         @(posedge core_clk) #1;
      `CHK("state", e, prog_state)
      if (prog_state !== e)
         final_report();
   endtask

   initial
   begin
      reset_n = 1'b0;
      ctx_sync = 1'b0;
      n_errors = 0;
      compares = 0;
      for (int p = 0; p < 3; p++)
      begin
         wr_s[p] = 1'b0;
         rd_s[p] = 1'b0;
         sel_s[p] = 4'h0;
         wd_s[p] = 32'h0000_0000;
      end
      repeat (6) @(posedge core_clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("idle", 1'b1, status_idle)
      `CHK("stable", 1'b1, model_stable_flag)
      `CHK("state", 3'h0, prog_state)
      $display("test reset done");
      // Idle programming from the debugger, internal write blocked by the freeze, reads from all three
      acc(1, 1'b1, trace_prog_pkg::SEL_CNTVAL, 32'h1234_ABCD);
      rdchk(1, trace_prog_pkg::SEL_CNTVAL, 32'h0000_ABCD);
      rdchk(2, trace_prog_pkg::SEL_CNTVAL, 32'h0000_ABCD);
      rdchk(0, trace_prog_pkg::SEL_CNTVAL, 32'h0000_ABCD);
      acc(2, 1'b1, trace_prog_pkg::SEL_CNTVAL, 32'h0000_0055);
      rdchk(1, trace_prog_pkg::SEL_CNTVAL, 32'h0000_ABCD);
      // Pin-driven auth word reaches direct reads only at a sync
      rdchk(0, trace_prog_pkg::SEL_AUTH, 32'h0000_0000);
      sync_pulse();
      rdchk(0, trace_prog_pkg::SEL_AUTH, 32'h0000_003C);
      rdchk(1, trace_prog_pkg::SEL_AUTH, 32'h0000_003C);
      $display("test idle access done");
      // Direct enable waits for a context sync
      acc(0, 1'b1, trace_prog_pkg::SEL_PRGCTL, 32'h0000_0001);
      `CHK("enable early", 1'b0, trace_enable)
      sync_pulse();
      wait_st(3'h1, 4);
      `CHK("idle", 1'b1, status_idle)
      wait_st(3'h2, trace_prog_pkg::ENABLE_CYCLES + 2);
      rdchk(0, trace_prog_pkg::SEL_STATUS, 32'h0000_0000);
      $display("test enable done");
      // Outside Idle only claim tags and the enable take debugger writes
      acc(1, 1'b1, trace_prog_pkg::SEL_CNTVAL, 32'h0000_0001);
      rdchk(1, trace_prog_pkg::SEL_CNTVAL, 32'h0000_ABCD);
      acc(1, 1'b1, trace_prog_pkg::SEL_CLAIMSET, 32'h0000_0005);
      acc(1, 1'b1, trace_prog_pkg::SEL_CLAIMCLR, 32'h0000_0001);
      rdchk(0, trace_prog_pkg::SEL_CLAIMCLR, 32'h0000_0004);
      // Internal resource write stays hidden from the debugger until Stable
      acc(2, 1'b1, trace_prog_pkg::SEL_RSR, 32'h0000_000F);
      rdchk(1, trace_prog_pkg::SEL_RSR, 32'h0000_0000);
      rdchk(2, trace_prog_pkg::SEL_RSR, 32'h0000_000F);
      $display("test running writes done");
      // Disable, try to re-enable while unstable, then drain to Idle
      acc(1, 1'b1, trace_prog_pkg::SEL_PRGCTL, 32'h0000_0000);
      wait_st(3'h3, 3);
      `CHK("stable", 1'b0, model_stable_flag)
      acc(1, 1'b1, trace_prog_pkg::SEL_PRGCTL, 32'h0000_0001);
      wait_st(3'h4, trace_prog_pkg::SETTLE_CYCLES + 2);
      `CHK("stable", 1'b1, model_stable_flag)
      `CHK("drained", 1'b0, trace_drained)
      rdchk(1, trace_prog_pkg::SEL_RSR, 32'h0000_000F);
      wait_st(3'h0, 40);
      repeat (8) @(posedge core_clk);
      #1;
      `CHK("enable", 1'b0, trace_enable)
      `CHK("state", 3'h0, prog_state)
      $display("test disable done");
      final_report();
   end

   // Watchdog on the whole run
   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      $display("[ERR] run watchdog exp done got hang");
      final_report();
   end
endmodule // trace_prog_ctrl_tb
